// file: hw/dcf_fifo.sv
// dcf_fifo: 8,192 x 18 first-in first-out buffer with standard and
// fall-through timing, half-full and programmable almost flags.
// assumes write and read clock pins are far slower than pclk (at least
// four pclk periods per phase); all link pins are synchronised to pclk here.
`timescale 1ns/1ps

// Summary of operation
// - mode pin latched while master reset low
// - low picks standard, high picks fall-through
// - standard mode: every word needs read enable
// - fall-through: first word shows after three edges
// - store data each write edge with enable low
// - standard empty flag rises after first write
// - almost-empty rises at n plus one words
// - half-full falls at 4,097 words
// - almost-full falls at depth minus m
// - standard full flag falls at 8,192, writes blocked
// - standard: first read from full raises full flag
// - almost-empty falls when count reaches n
// - standard empty flag falls after last word read
// - read enable ignored while buffer empty
// - empty and full pass two register stages
// - full side on write edges, empty side read
// - offset defaults 127 parallel, 1,023 serial
// - fall-through almost-empty rises at n plus two
// - fall-through capacity is 8,193 words
module dcf_fifo (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         ce,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         wr_clk_in,
    input  wire logic                         write_en_n,
    input  wire logic [dcf_pkg::DATA_W-1:0]   data_in,
    input  wire logic                         rd_clk_in,
    input  wire logic                         read_en_n,
    input  wire logic                         master_reset_n,
    input  wire logic                         timing_mode_select_in,
    input  wire logic                         offset_load_select,
    output logic      [dcf_pkg::DATA_W-1:0]   data_out,
    output logic                              empty_flag_n,
    output logic                              full_flag_n,
    output logic                              almost_empty_flag_n,
    output logic                              almost_full_flag_n,
    output logic                              half_full_flag_n
);

    // binary to gray for pointers that cross sides
    function automatic logic [dcf_pkg::PTR_W-1:0] bin2gray(input logic [dcf_pkg::PTR_W-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction

    // gray back to binary on the receiving side
    function automatic logic [dcf_pkg::PTR_W-1:0] gray2bin(input logic [dcf_pkg::PTR_W-1:0] g);
        logic [dcf_pkg::PTR_W-1:0] b;
        b = g;
        for (int i = dcf_pkg::PTR_W - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        gray2bin = b;
    endfunction

    // pin synchroniser: two flops before any logic
    logic [dcf_pkg::SYNC_W-1:0]  pin_raw;         // gathered pins
    logic [dcf_pkg::SYNC_W-1:0]  pin_s1_q;        // first stage, read only by second
    logic [dcf_pkg::SYNC_W-1:0]  pin_s2_q;        // second stage, safe to use
    logic                        wclk_prev_q;     // last write clock level
    logic                        rclk_prev_q;     // last read clock level
    logic                        wr_edge;         // write clock rising edge seen
    logic                        rd_edge;         // read clock rising edge seen
    logic                        wen_n_s;         // synced write enable
    logic                        ren_n_s;         // synced read enable
    logic                        mrst_n_s;        // synced master reset
    logic [dcf_pkg::DATA_W-1:0]  din_s;           // synced data word

    // mode and offsets
    logic                        fall_through_mode_q; // fall-through mode latched
    logic                        serial_q;        // serial offset loading latched
    logic [dcf_pkg::PTR_W-1:0]   empty_ofs_q;     // n
    logic [dcf_pkg::PTR_W-1:0]   full_ofs_q;      // m

    // storage and pointers
    logic [dcf_pkg::DATA_W-1:0]  mem [0:(1 << dcf_pkg::ADDR_W)-1];
    logic [dcf_pkg::PTR_W-1:0]   wptr_q;          // write pointer, binary
    logic [dcf_pkg::PTR_W-1:0]   wgray_q;         // write pointer, gray
    logic [dcf_pkg::PTR_W-1:0]   rptr_q;          // read pointer, binary
    logic [dcf_pkg::PTR_W-1:0]   rgray_q;         // read pointer, gray
    logic [dcf_pkg::PTR_W-1:0]   rsync_q;         // read gray seen by write side
    logic [dcf_pkg::PTR_W-1:0]   wsync1_q;        // write gray, first read stage
    logic [dcf_pkg::PTR_W-1:0]   wsync2_q;        // write gray, second read stage

    // internal flags, active high
    logic                        full_q;          // store full
    logic                        afull_q;         // at or above depth minus m
    logic                        half_q;          // above half
    logic                        ne_q;            // standard: not empty
    logic                        ov_q;            // fall-through: output word valid
    logic                        aempty_q;        // above empty threshold

    // next-state terms
    logic                        wr_ok;           // accepted write
    logic [dcf_pkg::PTR_W-1:0]   wptr_d;          // write pointer after this edge
    logic [dcf_pkg::PTR_W-1:0]   wcnt_d;          // write-side count after this edge
    logic                        rd_ok;           // standard: accepted read
    logic                        pop;             // fall-through: output consumed
    logic                        fetch;           // fall-through: load output reg
    logic                        adv;             // read pointer advances
    logic [dcf_pkg::PTR_W-1:0]   rptr_d;          // read pointer after this edge
    logic                        ov_d;            // output valid after this edge
    logic [dcf_pkg::PTR_W-1:0]   rcnt_d;          // read-side count after this edge

    // apb
    dcf_pkg::dcf_apb_state_t     apb_state_q;     // answer sequencer
    logic                        apb_hit;         // mapped address
    logic [31:0]                 apb_rdata;       // read mux

    assign pin_raw  = {wr_clk_in, rd_clk_in, write_en_n, read_en_n, master_reset_n,
                       timing_mode_select_in, offset_load_select, data_in};
    assign wr_edge  = pin_s2_q[24] & ~wclk_prev_q;
    assign rd_edge  = pin_s2_q[23] & ~rclk_prev_q;
    assign wen_n_s  = pin_s2_q[22];
    assign ren_n_s  = pin_s2_q[21];
    assign mrst_n_s = pin_s2_q[20];
    assign din_s    = pin_s2_q[dcf_pkg::DATA_W-1:0];

    // synchroniser and clock edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_q    <= 25'h0000000;
            pin_s2_q    <= 25'h0000000;
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            pin_s1_q    <= pin_raw;
            pin_s2_q    <= pin_s1_q;
            wclk_prev_q <= pin_s2_q[24];
            rclk_prev_q <= pin_s2_q[23];
        end
    end

    // mode and offset defaults caught during master reset, offsets writable over apb
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fall_through_mode_q <= 1'b0;
            serial_q    <= 1'b0;
            empty_ofs_q <= dcf_pkg::OFS_PAR_DEF;
            full_ofs_q  <= dcf_pkg::OFS_PAR_DEF;
        end
        else if (ce)
        begin
            if (!mrst_n_s)
            begin
                fall_through_mode_q <= pin_s2_q[19];
                serial_q    <= pin_s2_q[18];
                empty_ofs_q <= pin_s2_q[18] ? dcf_pkg::OFS_SER_DEF
                                            : dcf_pkg::OFS_PAR_DEF;
                full_ofs_q  <= pin_s2_q[18] ? dcf_pkg::OFS_SER_DEF
                                            : dcf_pkg::OFS_PAR_DEF;
            end
            else if (psel && penable && pready && pwrite)
            begin
                // write takes effect at the edge that completes the access
                if (paddr == dcf_pkg::REG_EMPTY_OFS)
                    empty_ofs_q <= pwdata[dcf_pkg::PTR_W-1:0];
                if (paddr == dcf_pkg::REG_FULL_OFS)
                    full_ofs_q  <= pwdata[dcf_pkg::PTR_W-1:0];
            end
        end
    end

    // write-side next state
    always_comb
    begin
        wr_ok  = ~wen_n_s & ~full_q;
        wptr_d = wptr_q + {{(dcf_pkg::PTR_W-1){1'b0}}, wr_ok};
        wcnt_d = wptr_d - gray2bin(rsync_q);
    end

    // write side: pointer and full-side flags move only on write clock edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wptr_q  <= 14'h0000;
            wgray_q <= 14'h0000;
            rsync_q <= 14'h0000;
            full_q  <= 1'b0;
            afull_q <= 1'b0;
            half_q  <= 1'b0;
        end
        else if (ce)
        begin
            if (!mrst_n_s)
            begin
                wptr_q  <= 14'h0000;
                wgray_q <= 14'h0000;
                rsync_q <= 14'h0000;
                full_q  <= 1'b0;
                afull_q <= 1'b0;
                half_q  <= 1'b0;
            end
            else if (wr_edge)
            begin
                rsync_q <= rgray_q;
                wptr_q  <= wptr_d;
                wgray_q <= bin2gray(wptr_d);
                // in fall-through the output register adds the 8,193rd word
                full_q  <= (wcnt_d == dcf_pkg::DEPTH_CNT);
                afull_q <= (wcnt_d >= dcf_pkg::DEPTH_CNT - full_ofs_q);
                half_q  <= (wcnt_d > dcf_pkg::HALF_CNT);
            end
        end
    end

    // storage write port
    always_ff @(posedge pclk)
    begin
        if (ce && mrst_n_s && wr_edge && wr_ok)
            mem[wptr_q[dcf_pkg::ADDR_W-1:0]] <= din_s;
    end

    // read-side next state
    always_comb
    begin
        rd_ok  = ~ren_n_s & ne_q;
        pop    = ~ren_n_s & ov_q;
        fetch  = (gray2bin(wsync2_q) != rptr_q) & (~ov_q | pop);
        adv    = fall_through_mode_q ? fetch : rd_ok;
        rptr_d = rptr_q + {{(dcf_pkg::PTR_W-1){1'b0}}, adv};
        ov_d   = fetch | (ov_q & ~pop);
        rcnt_d = gray2bin(wsync2_q) - rptr_d
               + {{(dcf_pkg::PTR_W-1){1'b0}}, fall_through_mode_q & ov_d};
    end

    // read side: pointer, output word and empty-side flags on read clock edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rptr_q   <= 14'h0000;
            rgray_q  <= 14'h0000;
            wsync1_q <= 14'h0000;
            wsync2_q <= 14'h0000;
            ne_q     <= 1'b0;
            ov_q     <= 1'b0;
            aempty_q <= 1'b0;
            data_out <= 18'h00000;
        end
        else if (ce)
        begin
            if (!mrst_n_s)
            begin
                rptr_q   <= 14'h0000;
                rgray_q  <= 14'h0000;
                wsync1_q <= 14'h0000;
                wsync2_q <= 14'h0000;
                ne_q     <= 1'b0;
                ov_q     <= 1'b0;
                aempty_q <= 1'b0;
                data_out <= 18'h00000;
            end
            else if (rd_edge)
            begin
                wsync1_q <= wgray_q;
                wsync2_q <= wsync1_q;
                rptr_q   <= rptr_d;
                rgray_q  <= bin2gray(rptr_d);
                // second stage of the standard empty flag
                ne_q     <= (gray2bin(wsync1_q) != rptr_d);
                ov_q     <= ov_d;
                // above n in standard, above n plus one in fall-through
                aempty_q <= (rcnt_d > empty_ofs_q
                            + {{(dcf_pkg::PTR_W-1){1'b0}}, fall_through_mode_q});
                if (adv)
                    data_out <= mem[rptr_q[dcf_pkg::ADDR_W-1:0]];
            end
        end
    end

    // flag pins, empty and full polarity set by mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            empty_flag_n        <= 1'b0;
            full_flag_n         <= 1'b1;
            almost_empty_flag_n <= 1'b0;
            almost_full_flag_n  <= 1'b1;
            half_full_flag_n    <= 1'b1;
        end
        else if (ce)
        begin
            // standard: low when empty; fall-through: low when a word waits
            empty_flag_n        <= fall_through_mode_q ? ~ov_q : ne_q;
            // standard: low when full; fall-through: high when full
            full_flag_n         <= fall_through_mode_q ? full_q : ~full_q;
            almost_empty_flag_n <= aempty_q;
            almost_full_flag_n  <= ~afull_q;
            half_full_flag_n    <= ~half_q;
        end
    end

    // apb read decode
    always_comb
    begin
        apb_hit   = 1'b1;
        apb_rdata = 32'h00000000;
        case (paddr)
            dcf_pkg::REG_EMPTY_OFS: apb_rdata[dcf_pkg::PTR_W-1:0] = empty_ofs_q;
            dcf_pkg::REG_FULL_OFS:  apb_rdata[dcf_pkg::PTR_W-1:0] = full_ofs_q;
            dcf_pkg::REG_STATUS:
            begin
                apb_rdata[dcf_pkg::ST_FALL_THROUGH] = fall_through_mode_q;
                apb_rdata[dcf_pkg::ST_SERIAL_LOAD]  = serial_q;
                apb_rdata[dcf_pkg::ST_EMPTY_N]      = empty_flag_n;
                apb_rdata[dcf_pkg::ST_FULL_N]       = full_flag_n;
                apb_rdata[dcf_pkg::ST_AEMPTY_N]     = almost_empty_flag_n;
                apb_rdata[dcf_pkg::ST_AFULL_N]      = almost_full_flag_n;
                apb_rdata[dcf_pkg::ST_HALF_N]       = half_full_flag_n;
            end
            dcf_pkg::REG_RD_COUNT:
                apb_rdata[dcf_pkg::PTR_W-1:0] = gray2bin(wsync2_q) - rptr_q;
            default: apb_hit = 1'b0;                             // unmapped: error
        endcase
    end

    // apb answer: no wait state, data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_state_q <= dcf_pkg::DCF_APB_IDLE;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= 32'h00000000;
        end
        else if (ce)
        begin
            case (apb_state_q)
                dcf_pkg::DCF_APB_IDLE:
                begin
                    if (psel && !penable)
                    begin
                        pready      <= 1'b1;
                        pslverr     <= ~apb_hit;
                        prdata      <= pwrite ? 32'h00000000 : apb_rdata;
                        apb_state_q <= dcf_pkg::DCF_APB_ANS;
                    end
                end
                dcf_pkg::DCF_APB_ANS:
                begin
                    pready      <= 1'b0;
                    pslverr     <= 1'b0;
                    apb_state_q <= dcf_pkg::DCF_APB_IDLE;
                end
                default:
                begin
                    pready      <= 1'b0;
                    pslverr     <= 1'b0;
                    apb_state_q <= dcf_pkg::DCF_APB_IDLE;
                end
            endcase
        end
    end

endmodule // dcf_fifo

// file: hw/dcf_pkg.sv
// dcf_pkg: constants and types shared by the dual-clock flag-mode fifo.
// assumes one system clock (pclk) samples the write and read clock pins.
package dcf_pkg;

    // data path and storage geometry
    localparam int DATA_W = 18;                        // word width
    localparam int ADDR_W = 13;                        // 8,192-word store
    localparam int PTR_W  = 14;                        // address plus wrap bit
    localparam int SYNC_W = 25;                        // pins passing the synchroniser

    // word counts that mark the flag boundaries
    localparam logic [PTR_W-1:0] DEPTH_CNT = 14'h2000; // 8,192 words: full
    localparam logic [PTR_W-1:0] HALF_CNT  = 14'h1000; // above 4,096: half full

    // offset defaults chosen by the load-select pin at master reset
    localparam logic [PTR_W-1:0] OFS_PAR_DEF = 14'h007F; // 127, parallel loading
    localparam logic [PTR_W-1:0] OFS_SER_DEF = 14'h03FF; // 1,023, serial loading

    // apb register byte addresses
    localparam logic [7:0] REG_EMPTY_OFS = 8'h00;      // empty offset n, rw
    localparam logic [7:0] REG_FULL_OFS  = 8'h04;      // full offset m, rw
    localparam logic [7:0] REG_STATUS    = 8'h08;      // mode and flags, ro
    localparam logic [7:0] REG_RD_COUNT  = 8'h0C;      // read-side word count, ro

    // status register bit positions
    localparam int ST_FALL_THROUGH = 0;                // fall-through mode active
    localparam int ST_SERIAL_LOAD  = 1;                // serial offset loading chosen
    localparam int ST_EMPTY_N      = 2;                // empty / output-ready pin
    localparam int ST_FULL_N       = 3;                // full / input-ready pin
    localparam int ST_AEMPTY_N     = 4;                // almost-empty pin
    localparam int ST_AFULL_N      = 5;                // almost-full pin
    localparam int ST_HALF_N       = 6;                // half-full pin

    // apb answer sequencer
    typedef enum logic [1:0] {
        DCF_APB_IDLE = 2'b01,                          // waiting for a setup cycle
        DCF_APB_ANS  = 2'b10                           // access phase, pready high
    } dcf_apb_state_t;

endpackage

// file: tb/dcf_fifo_sva.sv
// dcf_fifo_sva: port checks for the flag-mode fifo
// assumes a bind into dcf_fifo and the single pclk domain
`timescale 1ns/1ps
module dcf_fifo_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        wr_clk_in,
    input wire logic        rd_clk_in,
    input wire logic        master_reset_n,
    input wire logic [17:0] data_out,
    input wire logic        empty_flag_n,
    input wire logic        full_flag_n,
    input wire logic        almost_empty_flag_n,
    input wire logic        almost_full_flag_n,
    input wire logic        half_full_flag_n
);
    logic [3:0] rd_age_q; // cycles since the read clock rose
    logic [3:0] wr_age_q; // cycles since the write clock rose
    logic       rd_q;     // read clock pin one cycle ago
    logic       wr_q;     // write clock pin one cycle ago
    logic       mapped;   // address hits one of the four registers
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // link edge ages restart on a rise and stay zero in master reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {rd_q, wr_q} <= 2'b00;
            rd_age_q <= 4'h0;
            wr_age_q <= 4'h0;
        end
        else
        begin
            {rd_q, wr_q} <= {rd_clk_in, wr_clk_in};
            rd_age_q <= ((rd_clk_in && !rd_q) || !master_reset_n) ? 4'h0
                      : rd_age_q + {3'h0, rd_age_q != 4'hF};
            wr_age_q <= ((wr_clk_in && !wr_q) || !master_reset_n) ? 4'h0
                      : wr_age_q + {3'h0, wr_age_q != 4'hF};
        end
    end
    ready_after_setup_a: assert property (psel && !penable && !pready |=> pready)
        else $error("no answer one cycle after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    err_unmapped_a: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped address answered without error");
    ok_mapped_a: assert property (pready && mapped |-> !pslverr)
        else $error("mapped address answered with error");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    data_hold_a: assert property (!$stable(data_out) |-> rd_age_q <= 4'd8)
        else $error("output word moved without a read clock edge");
    empty_side_a: assert property (
        !$stable(empty_flag_n) || !$stable(almost_empty_flag_n) |-> rd_age_q <= 4'd8)
        else $error("empty side flag moved away from a read edge");
    full_side_a: assert property (
        !$stable(full_flag_n) || !$stable(almost_full_flag_n) |-> wr_age_q <= 4'd8)
        else $error("full side flag moved away from a write edge");
    half_side_a: assert property ($changed(half_full_flag_n) |-> wr_age_q <= 4'd8)
        else $error("half-full flag moved away from a write edge");
endmodule // dcf_fifo_sva

bind dcf_fifo dcf_fifo_sva i_dcf_fifo_sva (.pclk, .presetn, .psel, .penable, .paddr,
    .pready, .pslverr, .wr_clk_in, .rd_clk_in, .master_reset_n, .data_out, .empty_flag_n,
    .full_flag_n, .almost_empty_flag_n, .almost_full_flag_n, .half_full_flag_n);

// file: tb/dcf_link_model.sv
// dcf_link_model: writer and reader logic beyond the fifo pins
// assumes pclk paces it; link clocks stand still between words
`timescale 1ns/1ps
module dcf_link_model (
    input  wire logic        pclk,
    output logic             wr_clk_in,
    output logic             write_en_n,
    output logic [17:0]      data_in,
    output logic             rd_clk_in,
    output logic             read_en_n
);
    localparam int HALF = 8; // pclk cycles per phase: 160 ns link period
    // idle levels at time zero
    initial
    begin
        {wr_clk_in, rd_clk_in} = 2'b00;
        {write_en_n, read_en_n} = 2'b11;
        data_in = 18'h0;
    end
    // one write clock period, word and enable held around the rise
    task automatic link_write(input logic [17:0] d);
        @(posedge pclk);
        write_en_n <= 1'b0;
        data_in <= d;
        repeat (HALF) @(posedge pclk);
        wr_clk_in <= 1'b1;
        repeat (HALF) @(posedge pclk);
        wr_clk_in <= 1'b0;
        write_en_n <= 1'b1;
        data_in <= ~d; // released bus never shows the stale word
    endtask
    // one read clock period; en_n low requests a word
    task automatic link_read(input logic en_n);
        @(posedge pclk);
        read_en_n <= en_n;
        repeat (HALF) @(posedge pclk);
        rd_clk_in <= 1'b1;
        repeat (HALF) @(posedge pclk);
        rd_clk_in <= 1'b0;
        read_en_n <= 1'b1;
    endtask
endmodule // dcf_link_model

// file: tb/dual_clock_fifo_flag_modes_tb.sv
// dual_clock_fifo_flag_modes_tb: self-checking bench for dcf_fifo
// assumes dcf_link_model drives the link pins, apb tasks the registers
`timescale 1ns/1ps
module dual_clock_fifo_flag_modes_tb;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed_v;
    logic wr_clk_in, write_en_n, rd_clk_in, read_en_n, err;
    logic master_reset_n, timing_mode_select_in, offset_load_select;
    logic [17:0] data_in, data_out, w;
    logic [17:0] wq[4]; // words written in standard mode
    logic emp_n, ful_n, ae_n, af_n, half_n;
    int num_errors, num_checks;
    dcf_fifo i_dcf_fifo (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .wr_clk_in, .write_en_n, .data_in, .rd_clk_in,
        .read_en_n, .master_reset_n, .timing_mode_select_in, .offset_load_select,
        .data_out, .empty_flag_n(emp_n), .full_flag_n(ful_n), .almost_empty_flag_n(ae_n),
        .almost_full_flag_n(af_n), .half_full_flag_n(half_n));
    dcf_link_model i_dcf_link_model (.pclk, .wr_clk_in, .write_en_n, .data_in,
        .rd_clk_in, .read_en_n);
    // 100 MHz system clock
    always #5 pclk = ~pclk;
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, waiting for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite} <= {2'b10, wr};
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            num_errors++;
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // read a register and compare its masked value
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask
    // master reset, mode pins moved only after it has settled
    task automatic mreset(input logic mode, input logic load);
        @(posedge pclk);
        {master_reset_n, timing_mode_select_in, offset_load_select} <= {1'b0, mode, load};
        repeat (10) @(posedge pclk);
        master_reset_n <= 1'b1;
        repeat (8) @(posedge pclk);
        {timing_mode_select_in, offset_load_select} <= {~mode, ~load};
        repeat (6) @(posedge pclk);
    endtask
    // expected almost-empty pin from word count, offset and mode
    function automatic logic [31:0] exp_ae(input int cnt, input int n, input logic ft);
        return 32'(ft ? (cnt > n + 1) : (cnt > n));
    endfunction
    // verdict
    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog: the sequence needs well under 5,000 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        results();
    end
    // main sequence
    initial
    begin
        {pclk, presetn, ce, psel, penable, pwrite} = 6'b001000;
        {paddr, pwdata} = '0;
        {master_reset_n, timing_mode_select_in, offset_load_select} = 3'b000;
        {num_errors, num_checks} = 0;
        seed_v = $urandom(32'hD735400C);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(dcf_pkg::REG_FULL_OFS, 32'hFFFFFFFF, 32'd127);
        apb(1'b0, 8'h10, 32'h0);
        check(32'(err), 32'h1);
        mreset(1'b0, 1'b0);
        apb(1'b1, dcf_pkg::REG_EMPTY_OFS, 32'd2); // n = 2
        apb(1'b1, dcf_pkg::REG_FULL_OFS, 32'd8190); // almost full from 2 words
        rd_chk(dcf_pkg::REG_STATUS, 32'h3, 32'h0);
        check(32'(emp_n), 32'h0);
        foreach (wq[i])
        begin
            wq[i] = 18'($urandom);
            i_dcf_link_model.link_write(wq[i]);
        end
        check({29'h0, ful_n, af_n, half_n}, 32'h5);
        // the count reaches the almost-empty compare on the third read edge
        repeat (3) i_dcf_link_model.link_read(1'b1);
        check(32'(emp_n), 32'h1);
        check(32'(ae_n), exp_ae(4, 2, 1'b0));
        check(32'(data_out), 32'h0);
        rd_chk(dcf_pkg::REG_RD_COUNT, 32'h3FFF, 32'd4);
        foreach (wq[i])
        begin
            i_dcf_link_model.link_read(1'b0);
            check(32'(data_out), 32'(wq[i]));
            check(32'(ae_n), exp_ae(3 - i, 2, 1'b0));
        end
        check(32'(emp_n), 32'h0);
        i_dcf_link_model.link_read(1'b0);
        check(32'(data_out), 32'(wq[3]));
        mreset(1'b1, 1'b1);
        rd_chk(dcf_pkg::REG_STATUS, 32'h3, 32'h3);
        rd_chk(dcf_pkg::REG_EMPTY_OFS, 32'h3FFF, 32'd1023);
        check(32'(emp_n), 32'h1);
        w = 18'($urandom);
        i_dcf_link_model.link_write(w);
        repeat (3) i_dcf_link_model.link_read(1'b1);
        check(32'(data_out), 32'(w));
        check(32'(emp_n), 32'h0);
        check(32'(ae_n), exp_ae(1, 1023, 1'b1));
        i_dcf_link_model.link_read(1'b0);
        check(32'(emp_n), 32'h1);
        // a write clock edge while ce is low must leave no word behind
        ce <= 1'b0;
        i_dcf_link_model.link_write(18'($urandom));
        ce <= 1'b1;
        repeat (3) i_dcf_link_model.link_read(1'b1);
        check(32'(emp_n), 32'h1);
        results();
    end
endmodule // dual_clock_fifo_flag_modes_tb
